// ==== hdl/tec_timer.sv ====
// Purpose: 16-bit timer channel, event count and trigger pulse modes
// Assumes: pins synchronous to CLOCK_IN; count clock enable from outside
// Notes:   interval mode as square wave source, on event edges or the count clock
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "tec_defines.svh"

module tec_timer
  import tec_pkg::*;
(
  input  wire logic        CLOCK_IN,
  input  wire logic        RESET_IN,
  input  wire logic        COUNT_CLOCK_EN_IN,
  input  wire logic        EVENT_IN,
  input  wire logic        TRIGGER_IN,
  input  wire logic [3:0]  ADDR_IN,
  input  wire logic [15:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [15:0] RDATA_OUT,
  output logic             WAVE_ZERO_OUT,
  output logic             WAVE_ONE_OUT,
  output logic             COMPARE_ZERO_IRQ_OUT,
  output logic             COMPARE_ONE_IRQ_OUT
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic edge_hit(input logic [1:0] sel, input logic cur,
                                    input logic prev);
    edge_hit = (sel[0] & cur & ~prev) | (sel[1] & ~cur & prev);
  endfunction

  function automatic logic [15:0] pad8(input logic [7:0] v);
    pad8 = {8'h00, v};
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  tec_bus_s    bus;
  tec_out_s    outs;
  tec_state_e  state_reg, state_next;
  logic [7:0]  control_zero_reg;
  logic [7:0]  control_one_reg;
  logic [7:0]  io_control_one_reg;
  logic [3:0]  edge_select_control_reg;
  logic [7:0]  option_zero_reg;
  logic [1:0]  irq_mask_reg;
  logic [15:0] compare_zero_value_reg;
  logic [15:0] compare_one_value_reg;
  logic [15:0] compare_buffer_zero_reg;
  logic [15:0] compare_buffer_one_reg;
  logic [15:0] counter_reg, counter_next;
  logic        event_prev_reg;
  logic        trigger_prev_reg;
  logic        wave_zero_reg, wave_zero_next;
  logic        wave_one_reg, wave_one_next;
  logic        irq_zero_reg, irq_zero_next;
  logic        irq_one_reg, irq_one_next;
  logic        soft_used_reg;
  logic [15:0] rdata_reg;

  assign bus = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire         wr_ctl0 = bus.wr && bus.addr == `TEC_OFS_CONTROL_ZERO;
  wire         wr_ctl1 = bus.wr && bus.addr == `TEC_OFS_CONTROL_ONE;
  wire         wr_cmp0 = bus.wr && bus.addr == `TEC_OFS_COMPARE_ZERO;
  wire         wr_cmp1 = bus.wr && bus.addr == `TEC_OFS_COMPARE_ONE;
  wire         enabled = control_zero_reg[`TEC_BIT_COUNTER_ENABLE];
  wire [2:0]   mode    = control_one_reg[2:0];
  wire         ev_clk  = control_one_reg[`TEC_BIT_EVENT_CLOCK];
  wire         mode_ev = mode == `TEC_MODE_EVENT;
  wire         mode_tr = mode == `TEC_MODE_TRIGGER;
  wire         mode_iv = mode == `TEC_MODE_INTERVAL;
  wire [1:0]   trig_sel = edge_select_control_reg[1:0];
  wire [1:0]   event_sel = edge_select_control_reg[3:2];
  wire         event_edge = edge_hit(event_sel, EVENT_IN, event_prev_reg);
  wire         ext_trig   = edge_hit(trig_sel, TRIGGER_IN, trigger_prev_reg);
  // Soft trigger is a write-one pulse, not kept in control one; soft_used_reg notes that one came
  wire         soft_trig  = wr_ctl1 && bus.wdata[`TEC_BIT_SOFT_TRIGGER];
  wire         trigger    = mode_tr && (ext_trig || soft_trig);
  // Event modes tick on event edges, trigger mode on the count clock enable
  wire         tick = (mode_ev || (mode_iv && ev_clk)) ? event_edge
                                                       : COUNT_CLOCK_EN_IN;
  wire         match0 = counter_reg == compare_buffer_zero_reg;
  wire         match1 = counter_reg == compare_buffer_one_reg;
  wire         clear  = tick && match0;

  // First load on start; event/interval take compare writes at once
  wire start   = state_reg == TEC_ST_STOP && enabled;
  wire load0   = start || (mode_tr ? clear && state_reg == TEC_ST_RUN : 1'b1);
  wire load1   = start || (mode_tr ? clear && state_reg == TEC_ST_RUN : 1'b1);
  // Buffer one as it will stand after this edge, for the trigger-mode lookahead
  wire [15:0] next_buf1 = load1 ? compare_one_value_reg : compare_buffer_one_reg;

  // ****************************************************************
  // Counter and wave logic
  // ****************************************************************
  always_comb begin
    state_next     = state_reg;
    counter_next   = counter_reg;
    wave_zero_next = wave_zero_reg;
    wave_one_next  = wave_one_reg;
    irq_zero_next  = 1'b0;
    irq_one_next   = 1'b0;
    unique case (state_reg)
      TEC_ST_STOP: begin
        counter_next = `TEC_CNT_IDLE;
        if (enabled) begin
          state_next = mode_tr ? TEC_ST_WAIT : TEC_ST_RUN;
          // Event count starts from zero so the first irq needs cmp0+1 edges
          if (mode_ev) begin
            counter_next = `TEC_RST_WORD;
          end
        end
      end
      TEC_ST_WAIT: begin
        if (trigger) begin
          state_next     = TEC_ST_RUN;
          counter_next   = `TEC_RST_WORD;
          wave_one_next  = 1'b1;
          wave_zero_next = ~wave_zero_reg;
        end
      end
      TEC_ST_RUN: begin
        if (mode_tr && trigger) begin
          // Trigger beats a same-cycle match; that irq is dropped
          counter_next   = `TEC_RST_WORD;
          wave_one_next  = 1'b1;
          wave_zero_next = ~wave_zero_reg;
        end else if (tick) begin
          if (clear) begin
            counter_next   = `TEC_RST_WORD;
            irq_zero_next  = 1'b1;
            wave_zero_next = (mode_tr || mode_iv) ? ~wave_zero_reg : wave_zero_reg;
            if (mode_tr) begin
              wave_one_next = 1'b1;
            end
          end else begin
            // Wraps through FFFF when the buffer was lowered under the count
            counter_next = counter_reg + `TEC_CNT_ONE;
          end
          if (mode_tr && counter_next == next_buf1) begin
            // Falls as the count reaches buffer one: width is buffer one ticks
            irq_one_next  = 1'b1;
            wave_one_next = 1'b0;
          end else if (!mode_tr && match1) begin
            irq_one_next = 1'b1;
            if (mode_iv) begin
              wave_one_next = ~wave_one_reg;
            end
          end
        end
      end
      default: state_next = TEC_ST_STOP;
    endcase
    if (!enabled) begin
      state_next     = TEC_ST_STOP;
      counter_next   = `TEC_CNT_IDLE;
      wave_zero_next = 1'b0;
      wave_one_next  = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state_reg               <= TEC_ST_STOP;
      counter_reg             <= `TEC_CNT_IDLE;
      compare_buffer_zero_reg <= `TEC_RST_WORD;
      compare_buffer_one_reg  <= `TEC_RST_WORD;
      wave_zero_reg           <= 1'b0;
      wave_one_reg            <= 1'b0;
      irq_zero_reg            <= 1'b0;
      irq_one_reg             <= 1'b0;
      event_prev_reg          <= 1'b0;
      trigger_prev_reg        <= 1'b0;
    end else begin
      state_reg        <= state_next;
      counter_reg      <= counter_next;
      wave_zero_reg    <= wave_zero_next;
      wave_one_reg     <= wave_one_next;
      irq_zero_reg     <= irq_zero_next;
      irq_one_reg      <= irq_one_next;
      event_prev_reg   <= EVENT_IN;
      trigger_prev_reg <= TRIGGER_IN;
      if (load0) begin
        compare_buffer_zero_reg <= compare_zero_value_reg;
      end
      if (load1) begin
        compare_buffer_one_reg <= compare_one_value_reg;
      end
    end
  end

  // ****************************************************************
  // Register port
  // ****************************************************************
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      control_zero_reg        <= `TEC_RST_BYTE;
      control_one_reg         <= `TEC_RST_BYTE;
      io_control_one_reg      <= `TEC_RST_BYTE;
      edge_select_control_reg <= 4'h0;
      option_zero_reg         <= `TEC_RST_BYTE;
      irq_mask_reg            <= 2'h0;
      compare_zero_value_reg  <= `TEC_RST_WORD;
      compare_one_value_reg   <= `TEC_RST_WORD;
      soft_used_reg           <= 1'b0;
    end else begin
      if (wr_ctl0) begin
        control_zero_reg <= bus.wdata[7:0];
      end
      if (wr_ctl1) begin
        control_one_reg <= bus.wdata[7:0] & 8'hBF;
      end
      if (soft_trig) begin
        soft_used_reg <= 1'b1;
      end
      if (bus.wr && bus.addr == `TEC_OFS_IO_CONTROL_ONE) begin
        io_control_one_reg <= bus.wdata[7:0];
      end
      if (bus.wr && bus.addr == `TEC_OFS_EDGE_SELECT) begin
        edge_select_control_reg <= bus.wdata[3:0];
      end
      if (bus.wr && bus.addr == `TEC_OFS_OPTION_ZERO) begin
        option_zero_reg <= bus.wdata[7:0] & 8'hFE;
      end
      if (bus.wr && bus.addr == `TEC_OFS_IRQ_MASK) begin
        irq_mask_reg <= bus.wdata[1:0];
      end
      if (wr_cmp0) begin
        compare_zero_value_reg <= bus.wdata;
      end
      if (wr_cmp1) begin
        compare_one_value_reg <= bus.wdata;
      end
    end
  end

  wire [15:0] rd_mux =
    (bus.addr == `TEC_OFS_CONTROL_ZERO)   ? pad8(control_zero_reg) :
    (bus.addr == `TEC_OFS_CONTROL_ONE)    ? pad8(control_one_reg) :
    (bus.addr == `TEC_OFS_IO_CONTROL_ONE) ? pad8(io_control_one_reg) :
    (bus.addr == `TEC_OFS_EDGE_SELECT)    ? {12'h000, edge_select_control_reg} :
    (bus.addr == `TEC_OFS_OPTION_ZERO)    ? pad8(option_zero_reg) :
    (bus.addr == `TEC_OFS_COUNTER_READ)   ? counter_reg :
    (bus.addr == `TEC_OFS_COMPARE_ZERO)   ? compare_zero_value_reg :
    (bus.addr == `TEC_OFS_COMPARE_ONE)    ? compare_one_value_reg :
    (bus.addr == `TEC_OFS_IRQ_MASK)       ? {14'h0000, irq_mask_reg} :
                                            `TEC_RST_WORD;

  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rdata_reg <= `TEC_RST_WORD;
    end else begin
      rdata_reg <= bus.rd ? rd_mux : `TEC_RST_WORD;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Event count mode keeps both wave pins low; wave zero shown in interval
  // mode, and in trigger mode only after a soft trigger
  assign outs = '{
    wave_zero: (mode_iv || (mode_tr && soft_used_reg)) && wave_zero_reg,
    wave_one:  (mode_iv || mode_tr) && wave_one_reg,
    irq_zero:  irq_zero_reg && !irq_mask_reg[`TEC_BIT_MASK_ZERO],
    irq_one:   irq_one_reg && !irq_mask_reg[`TEC_BIT_MASK_ONE]
  };

  assign RDATA_OUT            = rdata_reg;
  assign WAVE_ZERO_OUT        = outs.wave_zero;
  assign WAVE_ONE_OUT         = outs.wave_one;
  assign COMPARE_ZERO_IRQ_OUT = outs.irq_zero;
  assign COMPARE_ONE_IRQ_OUT  = outs.irq_one;

endmodule // tec_timer

// ==== hdl/tec_defines.svh ====
// Purpose: offsets, field positions, reset values for the timer channel
// Assumes: 16-bit register port, word per offset
// Notes:   included by the top module and the assertion module
`ifndef TEC_DEFINES_SVH
`define TEC_DEFINES_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define TEC_OFS_CONTROL_ZERO   4'h0
`define TEC_OFS_CONTROL_ONE    4'h1
`define TEC_OFS_IO_CONTROL_ONE 4'h2
`define TEC_OFS_EDGE_SELECT    4'h3
`define TEC_OFS_OPTION_ZERO    4'h4
`define TEC_OFS_COUNTER_READ   4'h5
`define TEC_OFS_COMPARE_ZERO   4'h6
`define TEC_OFS_COMPARE_ONE    4'h7
`define TEC_OFS_IRQ_MASK       4'h8
// ****************************************************************
// Field positions
// ****************************************************************
`define TEC_BIT_COUNTER_ENABLE 7
`define TEC_BIT_SOFT_TRIGGER   6
`define TEC_BIT_EVENT_CLOCK    5
`define TEC_BIT_MASK_ONE       1
`define TEC_BIT_MASK_ZERO      0
`define TEC_BIT_OVERFLOW       0
// ****************************************************************
// Reset values and constants
// ****************************************************************
`define TEC_RST_BYTE           8'h00
`define TEC_RST_WORD           16'h0000
`define TEC_CNT_IDLE           16'hFFFF
`define TEC_CNT_ONE            16'h0001
`define TEC_MODE_INTERVAL      3'h0
`define TEC_MODE_EVENT         3'h1
`define TEC_MODE_TRIGGER       3'h2
`endif

// ==== hdl/tec_pkg.sv ====
// Purpose: types shared by the timer channel
// Assumes: tec_defines.svh holds the numbers
// Notes:   none
package tec_pkg;
  typedef enum logic [1:0] {
    TEC_EDGE_NONE = 2'b00,
    TEC_EDGE_RISE = 2'b01,
    TEC_EDGE_FALL = 2'b10,
    TEC_EDGE_BOTH = 2'b11
  } tec_edge_e;

  typedef enum logic [1:0] {
    TEC_ST_STOP = 2'b00,
    TEC_ST_WAIT = 2'b01,
    TEC_ST_RUN  = 2'b10
  } tec_state_e;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tec_bus_s;

  typedef struct packed {
    logic wave_zero;
    logic wave_one;
    logic irq_zero;
    logic irq_one;
  } tec_out_s;
endpackage

// ==== bench/tec_timer_sva.sv ====
// Purpose: port-level checks for the timer channel
// Assumes: mode, enable and mask mirrored from register writes
// Notes:   irq one mask bit is mirrored so masked runs stay quiet
`timescale 1ns/1ps
`include "tec_defines.svh"
module tec_timer_sva
  import tec_pkg::*;
(
  input wire logic        CLOCK_IN,
  input wire logic        RESET_IN,
  input wire logic        COUNT_CLOCK_EN_IN,
  input wire logic        EVENT_IN,
  input wire logic        TRIGGER_IN,
  input wire logic [3:0]  ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [15:0] RDATA_OUT,
  input wire logic        WAVE_ZERO_OUT,
  input wire logic        WAVE_ONE_OUT,
  input wire logic        COMPARE_ZERO_IRQ_OUT,
  input wire logic        COMPARE_ONE_IRQ_OUT
);
  // ****************************************************************
  // Mirrored control state and properties
  // ****************************************************************
  logic [2:0] mode_reg;
  logic       en_reg;
  logic       mask_one_reg;
  wire        wr_ctl0 = WR_IN && (ADDR_IN == `TEC_OFS_CONTROL_ZERO);
  wire        wr_ctl1 = WR_IN && (ADDR_IN == `TEC_OFS_CONTROL_ONE);
  wire        wr_mask = WR_IN && (ADDR_IN == `TEC_OFS_IRQ_MASK);
  wire        trig_w  = (mode_reg == `TEC_MODE_TRIGGER) && en_reg;
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      mode_reg     <= 3'h0;
      en_reg       <= 1'b0;
      mask_one_reg <= 1'b0;
    end else begin
      if (wr_ctl1) mode_reg <= WDATA_IN[2:0];
      if (wr_ctl0) en_reg <= WDATA_IN[`TEC_BIT_COUNTER_ENABLE];
      if (wr_mask) mask_one_reg <= WDATA_IN[`TEC_BIT_MASK_ONE];
    end
  end
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);
  property p_rdata_idle; !$past(RD_IN) |-> RDATA_OUT == 16'h0000; endproperty
  property p_edge_upper;
    $past(RD_IN && ADDR_IN == `TEC_OFS_EDGE_SELECT) |-> RDATA_OUT[15:4] == 12'h000;
  endproperty
  property p_no_ovf;
    $past(RD_IN && ADDR_IN == `TEC_OFS_OPTION_ZERO) |-> !RDATA_OUT[`TEC_BIT_OVERFLOW];
  endproperty
  property p_soft_reads0;
    $past(RD_IN && ADDR_IN == `TEC_OFS_CONTROL_ONE) |-> !RDATA_OUT[`TEC_BIT_SOFT_TRIGGER];
  endproperty
  property p_evt_quiet;
    mode_reg == `TEC_MODE_EVENT |-> !WAVE_ZERO_OUT && !WAVE_ONE_OUT;
  endproperty
  property p_fall_irq1;
    trig_w && $past(trig_w) && !mask_one_reg && $fell(WAVE_ONE_OUT) |-> COMPARE_ONE_IRQ_OUT;
  endproperty
  property p_irq0_wave1;
    trig_w && $past(trig_w) && COMPARE_ZERO_IRQ_OUT |-> WAVE_ONE_OUT;
  endproperty
  // Two cycles of slack for a pulse already launched at the stop
  property p_stop_quiet;
    !en_reg && !$past(en_reg) && !$past(en_reg, 2)
      |-> !COMPARE_ZERO_IRQ_OUT && !COMPARE_ONE_IRQ_OUT;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  a_edge_upper: assert property (p_edge_upper) else $error("edge upper bits set");
  a_no_ovf: assert property (p_no_ovf) else $error("overflow flag set");
  a_soft_reads0: assert property (p_soft_reads0) else $error("soft bit reads one");
  a_evt_quiet: assert property (p_evt_quiet) else $error("wave in event mode");
  a_fall_irq1: assert property (p_fall_irq1) else $error("fall without irq1");
  a_irq0_wave1: assert property (p_irq0_wave1) else $error("wave1 low at clear");
  a_stop_quiet: assert property (p_stop_quiet) else $error("irq while stopped");
  c_evt_irq0: cover property (mode_reg == `TEC_MODE_EVENT && COMPARE_ZERO_IRQ_OUT);
  c_trig_fall: cover property (trig_w && $fell(WAVE_ONE_OUT));
  c_cnt_read: cover property (RD_IN && ADDR_IN == `TEC_OFS_COUNTER_READ);
endmodule // tec_timer_sva
bind tec_timer tec_timer_sva u_sva (.CLOCK_IN, .RESET_IN, .COUNT_CLOCK_EN_IN, .EVENT_IN,
  .TRIGGER_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT, .WAVE_ZERO_OUT,
  .WAVE_ONE_OUT, .COMPARE_ZERO_IRQ_OUT, .COMPARE_ONE_IRQ_OUT);

// ==== bench/tec_pin_model.sv ====
// Purpose: far-side pins: event and trigger sources, wave observers
// Assumes: pins change right after a rising edge
// Notes:   counters run free; the bench works with differences
`timescale 1ns/1ps
module tec_pin_model (
  input  wire logic clk_in,
  input  wire logic wave_zero_in,
  input  wire logic wave_one_in,
  output logic      event_out,
  output logic      trigger_out
);
  // ****************************************************************
  // Pin drivers and wave counters
  // ****************************************************************
  int   hi_cnt  = 0;
  int   tog_cnt = 0;
  logic z_prev  = 1'b0;
  initial begin
    event_out   = 1'b0;
    trigger_out = 1'b0;
  end
  task automatic events(input int n);
    repeat (n) begin
      @(posedge clk_in) event_out <= 1'b1;
      @(posedge clk_in) event_out <= 1'b0;
    end
  endtask
  // One edge per cycle, the fastest the sampler can resolve
  task automatic toggles(input int n);
    repeat (n) @(posedge clk_in) event_out <= ~event_out;
  endtask
  task automatic trigger_pulse;
    @(posedge clk_in) trigger_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    trigger_out <= 1'b0;
  endtask
  always @(posedge clk_in) begin
    if (wave_one_in === 1'b1) hi_cnt++;
    if (wave_zero_in !== z_prev) tog_cnt++;
    z_prev = wave_zero_in;
  end
endmodule // tec_pin_model

// ==== bench/tb.sv ====
// Purpose: register-level tests of event count and trigger pulse modes
// Assumes: count clock enable high, full-rate counting, except in the hold test
// Notes:   long wrap at FFFF uses both-edge events to stay short
`timescale 1ns/1ps
module tb;
  import tec_pkg::*;
  // ****************************************************************
  // Harness, tasks and test sequence
  // ****************************************************************
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  addr  = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic        cen   = 1'b1;
  logic [15:0] rdata, d;
  logic        w0, w1, i0, i1, ev, tg;
  int          miscompares = 0, compares = 0, n0 = 0, n1 = 0, k0, k1, h, t;
  initial forever #12.5 clock = ~clock;
  tec_timer dut (.CLOCK_IN(clock), .RESET_IN(reset), .COUNT_CLOCK_EN_IN(cen),
    .EVENT_IN(ev), .TRIGGER_IN(tg), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .WAVE_ZERO_OUT(w0), .WAVE_ONE_OUT(w1),
    .COMPARE_ZERO_IRQ_OUT(i0), .COMPARE_ONE_IRQ_OUT(i1));
  tec_pin_model pins (.clk_in(clock), .wave_zero_in(w0), .wave_one_in(w1),
    .event_out(ev), .trigger_out(tg));
  always @(posedge clock) begin
    if (i0 === 1'b1) n0++;
    if (i1 === 1'b1) n1++;
  end
  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (compares > 0 && miscompares == 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock) begin addr <= a; wdata <= v; wr <= 1'b1; end
    @(posedge clock) wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the read edge
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clock) begin addr <= a; rd <= 1'b1; end
    @(posedge clock) rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_irq0;
    repeat (300) begin
      @(posedge clock);
      if (i0 === 1'b1) break;
    end
    #1;
  endtask
  initial begin
    #2300000;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    rd_reg(4'h5, d); chk("count at reset", d, 16'hFFFF);
    wr_reg(4'h3, 16'hFFFF); rd_reg(4'h3, d); chk("edge select", d, 16'h000F);
    rd_reg(4'hF, d); chk("unmapped", d, 16'h0000);
    wr_reg(4'h2, 16'hFFFF);
    $display("test registers done");
    wr_reg(4'h3, 16'h0005); wr_reg(4'h6, 16'h0003); wr_reg(4'h7, 16'h0001);
    wr_reg(4'h8, 16'h0000); wr_reg(4'h1, 16'h0001); wr_reg(4'h0, 16'h0080);
    k0 = n0; k1 = n1;
    pins.events(6); repeat (3) @(posedge clock);
    rd_reg(4'h5, d); chk("event count", d, 16'h0002);
    rd_reg(4'h5, d); chk("count undisturbed", d, 16'h0002);
    pins.events(2); repeat (3) @(posedge clock);
    chk("irq0 per cycle", 16'(n0 - k0), 16'h0002);
    chk("irq1 per cycle", 16'(n1 - k1), 16'h0002);
    wr_reg(4'h8, 16'h0002); k1 = n1;
    pins.events(4); repeat (3) @(posedge clock);
    chk("irq1 masked", 16'(n1 - k1), 16'h0000);
    wr_reg(4'h8, 16'h0000); wr_reg(4'h7, 16'h0005); k0 = n0; k1 = n1;
    pins.events(8); repeat (3) @(posedge clock);
    chk("irq1 above cmp0", 16'(n1 - k1), 16'h0000);
    chk("irq0 above case", 16'(n0 - k0), 16'h0002);
    wr_reg(4'h0, 16'h0000); wr_reg(4'h3, 16'h000D); wr_reg(4'h6, 16'hFFFF);
    wr_reg(4'h0, 16'h0080);
    pins.toggles(65535); repeat (3) @(posedge clock);
    rd_reg(4'h5, d); chk("count at top", d, 16'hFFFF);
    k0 = n0; pins.toggles(1); repeat (3) @(posedge clock);
    chk("irq0 at wrap", 16'(n0 - k0), 16'h0001);
    rd_reg(4'h5, d); chk("count wrapped", d, 16'h0000);
    wr_reg(4'h0, 16'h0000); wr_reg(4'h1, 16'h0020); wr_reg(4'h6, 16'h0001);
    wr_reg(4'h0, 16'h0080); pins.events(1); t = pins.tog_cnt;
    pins.events(2); repeat (3) @(posedge clock);
    chk("interval wave0", 16'(pins.tog_cnt - t), 16'h0002);
    $display("test event count done");
    wr_reg(4'h0, 16'h0000);
    wr_reg(4'h1, 16'h0002); wr_reg(4'h6, 16'h0003); wr_reg(4'h7, 16'h0001);
    wr_reg(4'h0, 16'h0080); k0 = n0;
    repeat (10) @(posedge clock);
    rd_reg(4'h5, d); chk("waiting count", d, 16'hFFFF);
    chk("no irq0 waiting", 16'(n0 - k0), 16'h0000);
    wr_reg(4'h1, 16'h0042);
    wait_irq0();
    h = pins.hi_cnt; t = pins.tog_cnt; k0 = n0;
    repeat (8) @(posedge clock);
    #1 chk("pwm active cycles", 16'(pins.hi_cnt - h), 16'h0002);
    chk("pwm periods", 16'(n0 - k0), 16'h0002);
    chk("wave0 toggles", 16'(pins.tog_cnt - t), 16'h0002);
    wr_reg(4'h7, 16'h0020); wr_reg(4'h6, 16'h003F);
    wait_irq0(); k0 = n0;
    repeat (64) @(posedge clock);
    #1 chk("reload at clear", 16'(n0 - k0), 16'h0001);
    repeat (40) @(posedge clock);
    t = pins.tog_cnt;
    pins.trigger_pulse();
    rd_reg(4'h5, d); chk("restart count", 16'(d < 16'h0008), 16'h0001);
    chk("wave1 on restart", 16'(w1), 16'h0001);
    chk("wave0 on restart", 16'(pins.tog_cnt - t), 16'h0001);
    @(posedge clock) cen <= 1'b0;
    repeat (10) @(posedge clock);
    rd_reg(4'h5, d); chk("count held", d, 16'h0004);
    $display("test trigger pulse done");
    print_verdict();
  end
endmodule // tb
